// >>> verilog/oad_regs.vh
// Constants for the opcode and addressing decoder
`ifndef OAD_REGS_VH
`define OAD_REGS_VH
// Prefix codes
`define OAD_PFX_SECOND_INDEX    8'h90
`define OAD_PFX_INDIRECT_SECOND 8'h91
`define OAD_PFX_INDIRECT        8'h92
// Addressing mode codes
`define OAD_MODE_INHERENT  4'h0
`define OAD_MODE_IMMEDIATE 4'h1
`define OAD_MODE_SHORT     4'h2
`define OAD_MODE_LONG      4'h3
`define OAD_MODE_INDEXED   4'h4
`define OAD_MODE_IDX_SHORT 4'h5
`define OAD_MODE_IDX_LONG  4'h6
`define OAD_MODE_ACC       4'h7
`define OAD_MODE_INDEX_REG 4'h8
`define OAD_MODE_BIT       4'h9
`define OAD_MODE_RELATIVE  4'hA
`define OAD_MODE_UNSUPP    4'hF
// Operation classes
`define OAD_CLASS_BIT_TEST 2'h0
`define OAD_CLASS_BIT_SET  2'h1
`define OAD_CLASS_SINGLE   2'h2
`define OAD_CLASS_DOUBLE   2'h3
`endif

// >>> verilog/oad_decoder.v
// Opcode and addressing-mode decoder with operand fetch
// ---------------------------------------------------------------------------
// Summary of operation
// - Operation and addressing mode both come from one opcode byte.
// - High nibble picks row/mode, low nibble picks operation within row.
// - A prefix switches the mode to second index, indirect, or both; indirect forms decode as OAD_MODE_UNSUPP.
// - Prefix 90h second index, 92h indirect, 91h indirect second index.
// - Immediate: operand is the byte after the opcode; two bytes total.
// - Direct short: one address byte, address 0 to 255; two bytes.
// - Direct long: two address bytes, high byte first; three bytes.
// - Indexed: 8-bit index is the address, below 100h; one byte.
// - Short offset indexed: offset plus index, untruncated, up to 1FEh.
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "oad_regs.vh"
module oad_decoder #(
  parameter ADDR_W = 16
) (
  input  wire              i_sys_clk,
  input  wire              i_rst_n,
  input  wire              i_start,
  input  wire [7:0]        i_index_first,
  input  wire [7:0]        i_index_second,
  output wire              o_fetch_req,
  output reg  [ADDR_W-1:0] o_fetch_addr,
  input  wire              i_fetch_valid,
  input  wire [7:0]        i_fetch_data,
  output reg               o_done,
  output reg  [7:0]        o_opcode,
  output reg  [3:0]        o_operation,
  output reg  [3:0]        o_mode,
  output reg  [1:0]        o_op_class,
  output reg  [2:0]        o_bit_num,
  output reg               o_bit_sense,
  output reg               o_use_second_index,
  output reg               o_indirect,
  output reg  [7:0]        o_immediate,
  output reg  [ADDR_W-1:0] o_eff_addr,
  output reg  [2:0]        o_length,
  output wire              o_busy
);

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_OPC  = 3'd1;
  localparam ST_OP1  = 3'd2;
  localparam ST_OP2  = 3'd3;
  localparam ST_DONE = 3'd4;

  reg [2:0]        state;
  reg [7:0]        opc;
  reg              pfx_second;
  reg              pfx_indirect;
  reg [7:0]        byte1;

  // ---------------------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------------------
  // Mode from the high nibble of an opcode
  function [3:0] oad_mode_of;
    input [3:0] row;
    begin
      case (row)
        4'h0, 4'h1: oad_mode_of = `OAD_MODE_BIT;
        4'h2:       oad_mode_of = `OAD_MODE_RELATIVE;
        4'h3:       oad_mode_of = `OAD_MODE_SHORT;
        4'h4:       oad_mode_of = `OAD_MODE_ACC;
        4'h5:       oad_mode_of = `OAD_MODE_INDEX_REG;
        4'h6:       oad_mode_of = `OAD_MODE_IDX_SHORT;
        4'h7:       oad_mode_of = `OAD_MODE_INDEXED;
        4'hA:       oad_mode_of = `OAD_MODE_IMMEDIATE;
        4'hB:       oad_mode_of = `OAD_MODE_SHORT;
        4'hC:       oad_mode_of = `OAD_MODE_LONG;
        4'hD:       oad_mode_of = `OAD_MODE_IDX_LONG;
        4'hE:       oad_mode_of = `OAD_MODE_IDX_SHORT;
        4'hF:       oad_mode_of = `OAD_MODE_INDEXED;
        default:    oad_mode_of = `OAD_MODE_INHERENT;
      endcase
    end
  endfunction

  // Operand bytes still to fetch after the opcode for a mode
  function [1:0] oad_extra_of;
    input [3:0] mode;
    begin
      case (mode)
        `OAD_MODE_IMMEDIATE, `OAD_MODE_SHORT, `OAD_MODE_IDX_SHORT: oad_extra_of = 2'd1;
        `OAD_MODE_LONG, `OAD_MODE_IDX_LONG:                        oad_extra_of = 2'd2;
        `OAD_MODE_BIT:                                             oad_extra_of = 2'd2;
        `OAD_MODE_RELATIVE:                                        oad_extra_of = 2'd1;
        default:                                                   oad_extra_of = 2'd0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Decode of the held opcode
  // ---------------------------------------------------------------------------
  // Row decode; the index register follows the prefix seen
  wire [3:0] cur_mode  = oad_mode_of(opc[7:4]);
  wire [1:0] cur_extra = oad_extra_of(cur_mode);
  wire [7:0] cur_index = pfx_second ? i_index_second : i_index_first;
  wire       is_prefix = (i_fetch_data == `OAD_PFX_SECOND_INDEX) ||
                         (i_fetch_data == `OAD_PFX_INDIRECT) ||
                         (i_fetch_data == `OAD_PFX_INDIRECT_SECOND);

  // Handshake outputs, combinational from state
  assign o_fetch_req = (state == ST_OPC) || (state == ST_OP1) || (state == ST_OP2);
  assign o_busy      = (state != ST_IDLE);

  // Unsupported combinations: relative and long-offset, indirect forms
  wire unsupported = (cur_mode == `OAD_MODE_IDX_LONG) || (cur_mode == `OAD_MODE_RELATIVE) || pfx_indirect;

  // ---------------------------------------------------------------------------
  // Fetch sequencer
  // ---------------------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state              <= ST_IDLE;
      opc                <= 8'h00;
      pfx_second         <= 1'b0;
      pfx_indirect       <= 1'b0;
      byte1              <= 8'h00;
      o_fetch_addr       <= {ADDR_W{1'b0}};
      o_done             <= 1'b0;
      o_opcode           <= 8'h00;
      o_operation        <= 4'h0;
      o_mode             <= `OAD_MODE_INHERENT;
      o_op_class         <= `OAD_CLASS_SINGLE;
      o_bit_num          <= 3'd0;
      o_bit_sense        <= 1'b0;
      o_use_second_index <= 1'b0;
      o_indirect         <= 1'b0;
      o_immediate        <= 8'h00;
      o_eff_addr         <= {ADDR_W{1'b0}};
      o_length           <= 3'd0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            state        <= ST_OPC;
            pfx_second   <= 1'b0;
            pfx_indirect <= 1'b0;
            o_length     <= 3'd0;
          end
        end
        ST_OPC: begin
          if (i_fetch_valid) begin
            o_fetch_addr <= o_fetch_addr + 1'b1;
            o_length     <= o_length + 3'd1;
            if (is_prefix && o_length == 3'd0) begin
              pfx_second   <= (i_fetch_data != `OAD_PFX_INDIRECT);
              pfx_indirect <= (i_fetch_data != `OAD_PFX_SECOND_INDEX);
            end else begin
              opc   <= i_fetch_data;
              state <= (oad_extra_of(oad_mode_of(i_fetch_data[7:4])) == 2'd0) ? ST_DONE : ST_OP1;
            end
          end
        end
        ST_OP1: begin
          if (i_fetch_valid) begin
            o_fetch_addr <= o_fetch_addr + 1'b1;
            o_length     <= o_length + 3'd1;
            byte1        <= i_fetch_data;
            state        <= (cur_extra == 2'd2) ? ST_OP2 : ST_DONE;
          end
        end
        ST_OP2: begin
          if (i_fetch_valid) begin
            o_fetch_addr <= o_fetch_addr + 1'b1;
            o_length     <= o_length + 3'd1;
            o_immediate  <= i_fetch_data;
            state        <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Latch the decoded fields at once with o_done; o_length and the ST_OP2 byte in o_immediate were set during the fetch
          o_done             <= 1'b1;
          o_opcode           <= opc;
          o_operation        <= opc[3:0];
          o_mode             <= unsupported ? `OAD_MODE_UNSUPP : cur_mode;
          o_use_second_index <= pfx_second;
          o_indirect         <= pfx_indirect;
          o_bit_num          <= opc[3:1];
          o_bit_sense        <= opc[0];
          if (opc[7:4] == 4'h0)
            o_op_class <= `OAD_CLASS_BIT_TEST;
          else if (opc[7:4] == 4'h1)
            o_op_class <= `OAD_CLASS_BIT_SET;
          else if (opc[7])
            o_op_class <= `OAD_CLASS_DOUBLE;
          else
            o_op_class <= `OAD_CLASS_SINGLE;
          case (cur_mode)
            `OAD_MODE_IMMEDIATE: begin
              o_immediate <= byte1;
              o_eff_addr  <= {ADDR_W{1'b0}};
            end
            `OAD_MODE_SHORT, `OAD_MODE_BIT:
              o_eff_addr <= {{(ADDR_W-8){1'b0}}, byte1};
            `OAD_MODE_LONG:
              o_eff_addr <= {byte1, o_immediate};
            `OAD_MODE_INDEXED:
              o_eff_addr <= {{(ADDR_W-8){1'b0}}, cur_index};
            `OAD_MODE_IDX_SHORT:
              o_eff_addr <= {{(ADDR_W-9){1'b0}}, {1'b0, byte1} + {1'b0, cur_index}};
            default:
              o_eff_addr <= {ADDR_W{1'b0}};
          endcase
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verification/oad_prog_mem.sv
// Program memory model answering the decoder's byte requests
`timescale 1ns/1ps
`default_nettype none
module oad_prog_mem (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slow,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  output var  logic        o_valid,
  output var  logic [7:0]  o_data
);
  logic [7:0] mem [0:31];
  // Answer next cycle; slow mode drops valid every other cycle
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_valid <= 1'b0;
    else
      o_valid <= i_req && !(i_slow && o_valid);
  end
  // Junk (inverted byte) while not valid
  always_comb o_data = o_valid ? mem[i_addr[4:0]] : ~mem[i_addr[4:0]];
endmodule
`default_nettype wire

// >>> verification/oad_decoder_sva.sv
// Port assertions for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "oad_regs.vh"
module oad_decoder_chk #(parameter ADDR_W = 16) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic              i_start,
  input wire logic [7:0]        i_index_first,
  input wire logic [7:0]        i_index_second,
  input wire logic              o_fetch_req,
  input wire logic [ADDR_W-1:0] o_fetch_addr,
  input wire logic              i_fetch_valid,
  input wire logic              o_done,
  input wire logic [7:0]        o_opcode,
  input wire logic [3:0]        o_operation,
  input wire logic [3:0]        o_mode,
  input wire logic [2:0]        o_bit_num,
  input wire logic              o_bit_sense,
  input wire logic              o_use_second_index,
  input wire logic              o_indirect,
  input wire logic [ADDR_W-1:0] o_eff_addr,
  input wire logic [2:0]        o_length,
  input wire logic              o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [2:0] pfx = {2'h0, o_use_second_index | o_indirect};
  sequence s_take; i_start && !o_busy; endsequence
  sequence s_fin(op); o_done && o_opcode == op && !o_indirect; endsequence
  sequence s_wait; o_fetch_req && !i_fetch_valid; endsequence
  sequence s_accept; o_fetch_req && i_fetch_valid; endsequence
  property p_hold; s_wait |=> $stable(o_fetch_addr); endproperty
  property p_step; s_accept |=> o_fetch_addr == $past(o_fetch_addr) + 1'b1; endproperty
  property p_busy; s_take |=> o_busy; endproperty
  property p_pulse; o_done |=> !o_done; endproperty
  property p_nib; o_done |-> o_operation == o_opcode[3:0]; endproperty
  property p_bit; o_done && o_opcode[7:5] == 3'h0 |-> o_bit_num == o_opcode[3:1] && o_bit_sense == o_opcode[0];
  endproperty
  property p_imm; s_fin(8'hA6) |-> o_mode == `OAD_MODE_IMMEDIATE && o_length == 3'h2 + pfx; endproperty
  property p_short; s_fin(8'hB6) |-> o_mode == `OAD_MODE_SHORT && o_eff_addr[15:8] == 8'h00; endproperty
  property p_long; s_fin(8'hC6) |-> o_mode == `OAD_MODE_LONG && o_length == 3'h3 + pfx; endproperty
  property p_idx; s_fin(8'hF6) |->
    o_eff_addr == {8'h00, o_use_second_index ? $past(i_index_second) : $past(i_index_first)}; endproperty
  property p_idxs; s_fin(8'hE6) |-> o_mode == `OAD_MODE_IDX_SHORT && o_eff_addr <= 16'h01FE; endproperty
  a_hold: assert property (p_hold) else $error("fetch address moved while waiting");
  a_step: assert property (p_step) else $error("fetch address not advanced by one");
  a_busy: assert property (p_busy) else $error("start not taken");
  a_pulse: assert property (p_pulse) else $error("done too long");
  a_nib: assert property (p_nib) else $error("operation nibble");
  a_bit: assert property (p_bit) else $error("bit fields");
  a_imm: assert property (p_imm) else $error("immediate");
  a_short: assert property (p_short) else $error("short direct");
  a_long: assert property (p_long) else $error("long direct");
  a_idx: assert property (p_idx) else $error("indexed address");
  a_idxs: assert property (p_idxs) else $error("offset indexed");
endmodule
bind oad_decoder oad_decoder_chk #(.ADDR_W(ADDR_W)) u_chk (
  .i_sys_clk          (i_sys_clk),
  .i_rst_n            (i_rst_n),
  .i_start            (i_start),
  .i_index_first      (i_index_first),
  .i_index_second     (i_index_second),
  .o_fetch_req        (o_fetch_req),
  .o_fetch_addr       (o_fetch_addr),
  .i_fetch_valid      (i_fetch_valid),
  .o_done             (o_done),
  .o_opcode           (o_opcode),
  .o_operation        (o_operation),
  .o_mode             (o_mode),
  .o_bit_num          (o_bit_num),
  .o_bit_sense        (o_bit_sense),
  .o_use_second_index (o_use_second_index),
  .o_indirect         (o_indirect),
  .o_eff_addr         (o_eff_addr),
  .o_length           (o_length),
  .o_busy             (o_busy)
);
`default_nettype wire

// >>> verification/oad_decoder_tb.sv
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "oad_regs.vh"
module oad_decoder_tb;
  logic clk = 0, rst_n = 0, start = 0, slow = 0;
  logic [7:0] ix1 = 8'h26, ix2 = 8'h3C;
  wire logic req, valid, done, busy, bs, sec, ind;
  wire logic [7:0] data, opc, imm;
  wire logic [15:0] fa, ea;
  wire logic [3:0] oper, mode;
  wire logic [2:0] bn, len;
  wire logic [1:0] cls;
  int err_count = 0, n_compared = 0, cyc = 0;
  logic [175:0] prog = 176'hA65AB6FFC61234F6E6FF90F692B61091F63A200D4005;
  oad_decoder u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_index_first(ix1),
    .i_index_second(ix2), .o_fetch_req(req), .o_fetch_addr(fa), .i_fetch_valid(valid),
    .i_fetch_data(data), .o_done(done), .o_opcode(opc), .o_operation(oper), .o_mode(mode),
    .o_op_class(cls), .o_bit_num(bn), .o_bit_sense(bs), .o_use_second_index(sec),
    .o_indirect(ind), .o_immediate(imm), .o_eff_addr(ea), .o_length(len), .o_busy(busy));
  oad_prog_mem u_mem (.i_sys_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_req(req),
    .i_addr(fa), .o_valid(valid), .o_data(data));
  initial forever #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    n_compared++;
    if (exp !== got) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One decode: start, bounded wait for done, check mode and length
  task automatic run(input logic [3:0] m, input logic [2:0] l);
    int i;
    @(posedge clk) #1 start = 1;
    @(posedge clk) #1 start = 0;
    for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk) #1;
    chk("done", 16'h0001, 16'(done));
    chk("busy", 16'h0000, 16'(busy));
    chk("mode", 16'(m), 16'(mode));
    chk("length", 16'(l), 16'(len));
  endtask
  // Immediate, short at page top, long high byte first
  task t_direct;
    run(`OAD_MODE_IMMEDIATE, 3'h2);
    chk("imm", 16'h005A, 16'(imm));
    run(`OAD_MODE_SHORT, 3'h2);
    chk("ea", 16'h00FF, ea);
    run(`OAD_MODE_LONG, 3'h3);
    chk("ea", 16'h1234, ea);
  endtask
  // Indexed and offset indexed at the top boundary, memory stalling
  task t_indexed;
    slow = 1;
    run(`OAD_MODE_INDEXED, 3'h1);
    chk("ea", 16'h0026, ea);
    ix1 = 8'hFF;
    run(`OAD_MODE_IDX_SHORT, 3'h2);
    chk("ea", 16'h01FE, ea);
    slow = 0;
  endtask
  // All three prefix codes
  task t_prefix;
    run(`OAD_MODE_INDEXED, 3'h2);
    chk("ea", 16'h003C, ea);
    chk("sec", 16'h0002, 16'({sec, ind}));
    run(`OAD_MODE_UNSUPP, 3'h3);
    chk("ind", 16'h0001, 16'({sec, ind}));
    run(`OAD_MODE_UNSUPP, 3'h2);
    chk("ind", 16'h0003, 16'({sec, ind}));
  endtask
  // Single-operand row and bit-test row
  task t_rows;
    run(`OAD_MODE_SHORT, 3'h2);
    chk("class", 16'(`OAD_CLASS_SINGLE), 16'(cls));
    chk("oper", 16'h000A, 16'(oper));
    chk("ea", 16'h0020, ea);
    run(`OAD_MODE_BIT, 3'h3);
    chk("class", 16'(`OAD_CLASS_BIT_TEST), 16'(cls));
    chk("bit", 16'h000D, 16'({bn, bs}));
    chk("ea", 16'h0040, ea);
    chk("disp", 16'h0005, 16'(imm));
    chk("fetch_addr", 16'h0016, fa);
  endtask
  initial begin
    for (int i = 0; i < 22; i++) u_mem.mem[i] = prog[8*(21-i) +: 8];
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    t_direct;
    t_indexed;
    t_prefix;
    t_rows;
    give_verdict;
  end
endmodule
`default_nettype wire
